// >>> mot_avg3.sv
// Mean of the last three recorded start consumptions
`timescale 1ns/1ps
module mot_avg3 (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       push,
	input  wire logic [6:0] sample,
	output logic      [6:0] mean
);
	logic [6:0]  hist_reg [3];
	logic [8:0]  sum;
	logic [17:0] scaled;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hist_reg[0] <= '0;
			hist_reg[1] <= '0;
			hist_reg[2] <= '0;
		end else if (push) begin
			hist_reg[0] <= sample;
			hist_reg[1] <= hist_reg[0];
			hist_reg[2] <= hist_reg[1];
		end
	end

	// Divide by three as multiply by 171/512, exact floor up to 300
	always_comb begin
		sum    = 9'(hist_reg[0]) + 9'(hist_reg[1]) + 9'(hist_reg[2]);
		scaled = 18'(sum) * 18'd171;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mean <= '0;
		end else begin
			mean <= scaled[15:9];
		end
	end

endmodule : mot_avg3

// >>> mot_motor_model.sv
// Behavioural motor, current sensor and keypad
`timescale 1ns/1ps
module mot_motor_model (
	input wire logic       clk,
	input wire logic       run_cmd,
	input wire logic       speed_cmd,
	input wire logic       ext_bypass,
	input wire logic       key_cmd,
	input wire logic [9:0] load_pct,
	input wire logic       motor_enable,
	output logic     [9:0] current_pct,
	output logic           motor_running,
	output logic           at_speed,
	output logic           bypass_closed,
	output logic           bypass_by_device,
	output logic           reset_key
);
	// Motor only turns while the block enables it, so a trip stops current
	logic spin;
	assign spin = run_cmd & motor_enable;
	initial begin
		current_pct = 10'h000;
		motor_running = 1'b0;
		at_speed = 1'b0;
		bypass_closed = 1'b0;
		bypass_by_device = 1'b1;
		reset_key = 1'b0;
	end
	always @(posedge clk) begin
		motor_running <= spin;
		at_speed <= spin & speed_cmd;
		bypass_closed <= spin & speed_cmd;
		bypass_by_device <= !ext_bypass;
		current_pct <= spin ? load_pct : 10'h000;
		reset_key <= key_cmd;
	end
endmodule : mot_motor_model

// >>> mot_overload.sv
// Motor thermal overload supervision with APB register access
`timescale 1ns/1ps
// Notes on behaviour
// R1: Restart need is mean of last three starts
// R2: Refuse trip reset until capacity regains need
// R3: Blocked reset attempt shows inhibit indication
// R4: Class N trips in N seconds at 600%
// R5: Start curve, then run curve once at speed
// R6: Start class accepts 5 through 30 only
// R7: Run class accepts multiples of five, 5-30
// R8: Both classes reset to class 10
// R9: Supervise during bypass when device drives contactor
// R10: Control power without line power flags indication
// R11: Emergency override lifts the reset inhibit
// R12: Remaining capacity percent, 100 when cool
// R13: Trip lamp steady, flashing once reset permitted
// R14: Trip latches; held reset cannot block trip
module mot_overload #(
	parameter int MS_CYCLES = mot_pkg::MOT_MS_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [9:0]  current_pct,
	input  wire logic        motor_running,
	input  wire logic        at_speed,
	input  wire logic        bypass_closed,
	input  wire logic        bypass_by_device,
	input  wire logic        control_power_ok,
	input  wire logic [2:0]  line_power_ok,
	input  wire logic        reset_key,
	output logic             motor_enable,
	output logic             overload_lamp,
	output logic             reset_inhibit_indication,
	output logic             no_line_power_indication,
	output logic [6:0]       restart_capacity_view,
	output logic             irq
);
	import mot_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [4:0]          start_trip_class_setting;
	logic [4:0]          run_trip_class_setting;
	logic                lockout_emergency_override;
	logic [MOT_IRQ_W-1:0] int_stat_reg;
	logic [MOT_IRQ_W-1:0] int_mask_reg;
	logic [16:0]         ms_cnt_reg;
	logic                ms_tick;
	logic [4:0]          cls_cnt_reg;
	logic                heat_tick;
	logic [9:0]          blink_cnt_reg;
	logic                blink_reg;
	logic [29:0]         heat_reg;
	logic [29:0]         heat_next;
	logic [19:0]         cur_sq;
	logic [39:0]         pct_prod;
	logic [6:0]          remaining_reg;
	logic                trip_reg;
	logic                permit;
	logic                supervise;
	logic [4:0]          active_class;
	logic                run_prev_reg;
	logic                speed_prev_reg;
	logic [6:0]          start_pct_reg;
	logic                start_push;
	logic [6:0]          start_used;
	logic [6:0]          mean_cap;
	logic                wr_en;
	logic                rd_en;
	logic                addr_ok;
	logic                trip_event;
	logic                inhibit_event;
	logic                noline_event;
	logic [MOT_IRQ_W-1:0] events;
	logic [31:0]         rd_value;
	logic [4:0]          wr_start;
	logic [4:0]          wr_run;

	// ----------------------------------------------------------------
	// APB slave: one wait state, response from flops
	// ----------------------------------------------------------------
	assign wr_en    = psel & penable & pready & pwrite;
	assign rd_en    = psel & penable & pready & ~pwrite;
	assign wr_start = pwdata[MOT_CFG_START_LSB +: 5];
	assign wr_run   = pwdata[MOT_CFG_RUN_LSB +: 5];

	always_comb begin
		addr_ok  = 1'b1;
		rd_value = '0;
		unique case (paddr)
			MOT_CLASS_CFG_ADDR: begin
				rd_value[MOT_CFG_START_LSB +: 5] = start_trip_class_setting;
				rd_value[MOT_CFG_RUN_LSB +: 5]   = run_trip_class_setting;
			end
			MOT_CTRL_ADDR: begin
				rd_value[MOT_CTRL_OVR_BIT] = lockout_emergency_override;
			end
			MOT_STATUS_ADDR: begin
				rd_value[6:0]               = remaining_reg;
				rd_value[MOT_ST_TRIP_BIT]   = trip_reg;
				rd_value[MOT_ST_INH_BIT]    = reset_inhibit_indication;
				rd_value[MOT_ST_PERMIT_BIT] = permit;
				rd_value[MOT_ST_NOLINE_BIT] = no_line_power_indication;
				rd_value[MOT_ST_RUNCRV_BIT] = at_speed;
			end
			MOT_RESTART_CAP_ADDR: begin
				rd_value[6:0] = restart_capacity_view;
			end
			MOT_INT_STAT_ADDR: begin
				rd_value[MOT_IRQ_W-1:0] = int_stat_reg;
			end
			MOT_INT_MASK_ADDR: begin
				rd_value[MOT_IRQ_W-1:0] = int_mask_reg;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addr_ok;
			if (psel & penable & ~pready & ~pwrite) begin
				prdata <= rd_value;
			end else if (rd_en) begin
				prdata <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Trip class settings and override
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			// R8: class ten default
			start_trip_class_setting   <= MOT_CLASS_DEFAULT;
			run_trip_class_setting     <= MOT_CLASS_DEFAULT;
			lockout_emergency_override <= 1'b0;
		end else if (wr_en) begin
			if (paddr == MOT_CLASS_CFG_ADDR) begin
				// R6: start range check
				if (wr_start >= MOT_CLASS_MIN && wr_start <= MOT_CLASS_MAX) begin
					start_trip_class_setting <= wr_start;
				end
				// R7: run steps of five
				if (wr_run >= MOT_CLASS_MIN && wr_run <= MOT_CLASS_MAX
					&& (wr_run % MOT_CLASS_STEP) == 5'h00) begin
					run_trip_class_setting <= wr_run;
				end
			end
			if (paddr == MOT_CTRL_ADDR) begin
				lockout_emergency_override <= pwdata[MOT_CTRL_OVR_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	// R5: curve follows at-speed
	assign active_class = at_speed ? run_trip_class_setting : start_trip_class_setting;
	assign ms_tick      = (ms_cnt_reg == 17'(MS_CYCLES - 1));
	// A class change mid-tick only stretches or shortens one tick
	assign heat_tick    = ms_tick && (cls_cnt_reg >= active_class - 5'h01);

	always_ff @(posedge clk) begin
		if (sys_rst || ms_tick) begin
			ms_cnt_reg <= '0;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 17'h0_0001;
		end
	end

	// R4: tick length is class ms
	always_ff @(posedge clk) begin
		if (sys_rst || heat_tick) begin
			cls_cnt_reg <= '0;
		end else if (ms_tick) begin
			cls_cnt_reg <= cls_cnt_reg + 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			blink_cnt_reg <= '0;
			blink_reg     <= 1'b0;
		end else if (ms_tick) begin
			if (blink_cnt_reg == MOT_BLINK_TICKS - 10'h001) begin
				blink_cnt_reg <= '0;
				blink_reg     <= ~blink_reg;
			end else begin
				blink_cnt_reg <= blink_cnt_reg + 10'h001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Thermal register
	// ----------------------------------------------------------------
	// R9: bypass counts only when driven here
	assign supervise = motor_running & (~bypass_closed | bypass_by_device);

	always_comb begin
		cur_sq    = supervise ? 20'(current_pct * current_pct) : 20'h0_0000;
		heat_next = heat_reg + 30'(cur_sq);
		// Heating at rated current balances cooling
		if (heat_next > 30'(MOT_RATED_SQ)) begin
			heat_next = heat_next - 30'(MOT_RATED_SQ);
		end else begin
			heat_next = '0;
		end
		if (heat_next > MOT_HEAT_FULL) begin
			heat_next = MOT_HEAT_FULL;
		end
		pct_prod = 40'(heat_reg) * 40'(MOT_PCT_RECIP);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			heat_reg <= '0;
		end else if (heat_tick) begin
			// R4: full at 600% for N s
			heat_reg <= heat_next;
		end
	end

	// R12: percent remaining
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			remaining_reg <= MOT_PCT_FULL;
		end else begin
			remaining_reg <= MOT_PCT_FULL - pct_prod[38:32];
		end
	end

	// ----------------------------------------------------------------
	// Trip latch and reset permission
	// ----------------------------------------------------------------
	// R2: reset needs regained capacity
	// R11: override lifts inhibit
	assign permit     = trip_reg &
		((remaining_reg >= restart_capacity_view) | lockout_emergency_override);
	assign trip_event = (heat_reg >= MOT_HEAT_FULL) & ~trip_reg;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trip_reg <= 1'b0;
		end else if (heat_reg >= MOT_HEAT_FULL) begin
			// R14: trip wins over reset
			trip_reg <= 1'b1;
		end else if (reset_key && permit) begin
			trip_reg <= 1'b0;
		end
	end

	assign inhibit_event = reset_key & trip_reg & ~permit;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reset_inhibit_indication <= 1'b0;
		end else if (inhibit_event) begin
			// R3: blocked attempt shown
			reset_inhibit_indication <= 1'b1;
		end else if (~trip_reg || permit) begin
			reset_inhibit_indication <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			motor_enable  <= 1'b0;
			overload_lamp <= 1'b0;
		end else begin
			// R14: motor held off
			motor_enable  <= ~trip_reg & (heat_reg < MOT_HEAT_FULL);
			// R13: steady, then flashing
			overload_lamp <= trip_reg & (~permit | blink_reg);
		end
	end

	// R10: no line power
	assign noline_event = control_power_ok & (line_power_ok == 3'b000);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			no_line_power_indication <= 1'b0;
		end else begin
			no_line_power_indication <= noline_event;
		end
	end

	// ----------------------------------------------------------------
	// Start capacity tracking
	// ----------------------------------------------------------------
	// Only starts that reach speed untripped are recorded
	assign start_push = at_speed & ~speed_prev_reg & motor_running & ~trip_reg;
	assign start_used = (start_pct_reg > remaining_reg) ?
		start_pct_reg - remaining_reg : 7'h00;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			run_prev_reg   <= 1'b0;
			speed_prev_reg <= 1'b0;
			start_pct_reg  <= MOT_PCT_FULL;
		end else begin
			run_prev_reg   <= motor_running;
			speed_prev_reg <= at_speed;
			if (motor_running && !run_prev_reg) begin
				start_pct_reg <= remaining_reg;
			end
		end
	end

	// R1: mean of three starts
	mot_avg3 u_avg (
		.clk     (clk),
		.sys_rst (sys_rst),
		.push    (start_push),
		.sample  (start_used),
		.mean    (mean_cap)
	);

	assign restart_capacity_view = mean_cap;

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	always_comb begin
		events                  = '0;
		events[MOT_IRQ_TRIP]    = trip_event;
		events[MOT_IRQ_INHIBIT] = inhibit_event;
		events[MOT_IRQ_NOLINE]  = noline_event & ~no_line_power_indication;
		events[MOT_IRQ_START]   = start_push;
	end

	// New events win over a same-cycle write-one-to-clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			int_stat_reg <= '0;
			int_mask_reg <= MOT_MASK_RESET;
		end else begin
			if (wr_en && paddr == MOT_INT_STAT_ADDR) begin
				int_stat_reg <= (int_stat_reg & ~pwdata[MOT_IRQ_W-1:0]) | events;
			end else begin
				int_stat_reg <= int_stat_reg | events;
			end
			if (wr_en && paddr == MOT_INT_MASK_ADDR) begin
				int_mask_reg <= pwdata[MOT_IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_stat_reg & int_mask_reg);
		end
	end

endmodule : mot_overload

// >>> mot_overload_assertions.sv
// Port-level checker for the motor overload block
`timescale 1ns/1ps
module mot_overload_assertions (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       at_speed,
	input wire logic       control_power_ok,
	input wire logic [2:0] line_power_ok,
	input wire logic       reset_key,
	input wire logic       motor_enable,
	input wire logic       overload_lamp,
	input wire logic       reset_inhibit_indication,
	input wire logic       no_line_power_indication,
	input wire logic [6:0] restart_capacity_view
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ----------------------------------------
	// Bus and indication checks
	// ----------------------------------------
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_no_line;
		control_power_ok && line_power_ok == 3'b000;
	endsequence

	a_ready_wait: assert property (s_setup ##1 s_access |=> pready)
		else $error("pready late after access phase");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	a_err_unmapped: assert property (psel && penable && pready && paddr > 8'h14 |-> pslverr)
		else $error("unmapped access not refused");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_line_flag: assert property (s_no_line [*2] |-> no_line_power_indication)
		else $error("missing line power not flagged");
	a_line_clear: assert property
		(!(control_power_ok && line_power_ok == 3'b000) [*2] |-> !no_line_power_indication)
		else $error("line power flag without cause");
	a_trip_latch: assert property ($rose(motor_enable) && !$past(sys_rst, 3)
		&& !$past(sys_rst, 4) |-> $past(reset_key) || $past(reset_key, 2) || $past(reset_key, 3))
		else $error("motor enabled without reset attempt");
	a_inh_cause: assert property ($rose(reset_inhibit_indication)
		|-> $past(reset_key) || $past(reset_key, 2))
		else $error("inhibit shown without attempt");
	a_inh_off: assert property (reset_inhibit_indication |-> !motor_enable)
		else $error("motor enabled while inhibited");
	a_inh_lamp: assert property (reset_inhibit_indication [*2] |-> overload_lamp)
		else $error("lamp not steady while inhibited");
	a_view_moves: assert property ($changed(restart_capacity_view) |->
		($past(at_speed) && !$past(at_speed, 2)) || ($past(at_speed, 2) && !$past(at_speed, 3))
		|| ($past(at_speed, 3) && !$past(at_speed, 4)))
		else $error("restart view moved without a start");
endmodule : mot_overload_assertions

// >>> mot_pkg.sv
// Constants shared by the motor overload trip logic
package mot_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] MOT_CLASS_CFG_ADDR   = 8'h00;
	localparam logic [7:0] MOT_CTRL_ADDR        = 8'h04;
	localparam logic [7:0] MOT_STATUS_ADDR      = 8'h08;
	localparam logic [7:0] MOT_RESTART_CAP_ADDR = 8'h0C;
	localparam logic [7:0] MOT_INT_STAT_ADDR    = 8'h10;
	localparam logic [7:0] MOT_INT_MASK_ADDR    = 8'h14;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MOT_CFG_START_LSB  = 0;
	localparam int MOT_CFG_RUN_LSB    = 8;
	localparam int MOT_CTRL_OVR_BIT   = 0;
	localparam int MOT_ST_TRIP_BIT    = 8;
	localparam int MOT_ST_INH_BIT     = 9;
	localparam int MOT_ST_PERMIT_BIT  = 10;
	localparam int MOT_ST_NOLINE_BIT  = 11;
	localparam int MOT_ST_RUNCRV_BIT  = 12;
	localparam int MOT_IRQ_TRIP       = 0;
	localparam int MOT_IRQ_INHIBIT    = 1;
	localparam int MOT_IRQ_NOLINE     = 2;
	localparam int MOT_IRQ_START      = 3;
	localparam int MOT_IRQ_W          = 4;

	// ----------------------------------------------------------------
	// Trip classes and reset values
	// ----------------------------------------------------------------
	localparam logic [4:0] MOT_CLASS_MIN     = 5'h05;
	localparam logic [4:0] MOT_CLASS_MAX     = 5'h1E;
	localparam logic [4:0] MOT_CLASS_STEP    = 5'h05;
	localparam logic [4:0] MOT_CLASS_DEFAULT = 5'h0A;
	localparam logic [6:0] MOT_PCT_FULL      = 7'h64;
	localparam logic [MOT_IRQ_W-1:0] MOT_MASK_RESET = 4'h0;

	// ----------------------------------------------------------------
	// Thermal model timing
	// ----------------------------------------------------------------
	localparam int MOT_CLK_HZ      = 100_000_000;
	localparam int MOT_BASE_MS     = 1;
	localparam int MOT_MS_CYCLES   = MOT_CLK_HZ / 1000 * MOT_BASE_MS;
	localparam int MOT_BLINK_MS    = 500;
	localparam logic [9:0] MOT_BLINK_TICKS = 10'(MOT_BLINK_MS / MOT_BASE_MS);
	// Heat per tick is the square of current in percent of full load;
	// one tick lasts N ms for class N, so 1000 ticks span N seconds
	localparam logic [9:0]  MOT_TRIP_PCT    = 10'd600;
	localparam logic [19:0] MOT_RATED_SQ    = 20'd10000;
	// Full scale nets out the cooling term, so a steady 600% fills it
	// in exactly 1000 ticks
	localparam logic [29:0] MOT_HEAT_FULL   =
		30'((20'(MOT_TRIP_PCT * MOT_TRIP_PCT) - MOT_RATED_SQ) * 1000);
	// Percent used = heat * MOT_PCT_RECIP / 2**32
	localparam logic [10:0] MOT_PCT_RECIP   = 11'd1228;

endpackage : mot_pkg

// >>> tb_top.sv
// Self-checking bench for the motor overload block
`timescale 1ns/1ps
module tb_top;
	import mot_pkg::*;
	logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, perr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0]  load_pct, cur;
	logic        run_cmd, speed_cmd, ext_byp, key_cmd, running, spd, byp_cl, byp_dev, rkey;
	logic        ctl_ok, motor_en, lamp, inh, noline, irq;
	logic [2:0]  line_ok;
	logic [6:0]  view;
	int          err_count = 0;
	int          n_compared = 0;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	mot_overload #(.MS_CYCLES(1)) dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .current_pct(cur), .motor_running(running),
		.at_speed(spd), .bypass_closed(byp_cl), .bypass_by_device(byp_dev),
		.control_power_ok(ctl_ok), .line_power_ok(line_ok), .reset_key(rkey),
		.motor_enable(motor_en), .overload_lamp(lamp), .reset_inhibit_indication(inh),
		.no_line_power_indication(noline), .restart_capacity_view(view), .irq(irq));

	mot_motor_model far_u (.clk(clk), .run_cmd(run_cmd), .speed_cmd(speed_cmd),
		.ext_bypass(ext_byp), .key_cmd(key_cmd), .load_pct(load_pct), .motor_enable(motor_en),
		.current_pct(cur), .motor_running(running), .at_speed(spd), .bypass_closed(byp_cl),
		.bypass_by_device(byp_dev), .reset_key(rkey));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task print_verdict;
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			err_count++;
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task give_up(input int n, input int lim);
		if (n >= lim) begin
			err_count++;
			print_verdict();
		end
	endtask : give_up

	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		give_up(n, 50);
		// Idle edge so back-to-back calls never drive psel twice at once
		@(posedge clk);
	endtask : apb

	task wait_en(input logic lvl, input int lim, output int n);
		n = 0;
		while (motor_en !== lvl && n < lim) begin
			@(posedge clk);
			n++;
		end
		give_up(n, lim);
	endtask : wait_en

	task press;
		key_cmd <= 1'b1;
		tick(1);
		key_cmd <= 1'b0;
		tick(4);
	endtask : press

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		int v, s, r;
		int vals[7];
		vals = '{4, 5, 31, 30, 12, 0, 25};
		apb(MOT_CLASS_CFG_ADDR, 1'b0, 32'h0);
		chk("class reset", 32'h0000_0A0A, rd);
		apb(MOT_STATUS_ADDR, 1'b0, 32'h0);
		chk("remaining", 32'h0000_0064, {25'h0, rd[6:0]});
		apb(MOT_RESTART_CAP_ADDR, 1'b0, 32'h0);
		chk("restart view", 32'h0, rd);
		chk("view port", 32'h0, {25'h0, view});
		apb(8'h40, 1'b0, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, perr});
		s = 10;
		r = 10;
		foreach (vals[i]) begin
			v = vals[i];
			apb(MOT_CLASS_CFG_ADDR, 1'b1, 32'(v * 257));
			if (v >= 5 && v <= 30)
				s = v;
			if (v >= 5 && v <= 30 && v % 5 == 0)
				r = v;
			apb(MOT_CLASS_CFG_ADDR, 1'b0, 32'h0);
			chk("class cfg", 32'(s + r * 256), rd);
		end
	endtask : t_regs

	task t_line;
		line_ok <= 3'b000;
		tick(3);
		chk("no line", 32'h1, {31'h0, noline});
		line_ok <= 3'b010;
		tick(3);
		chk("one line", 32'h0, {31'h0, noline});
		ctl_ok <= 1'b0;
		line_ok <= 3'b000;
		tick(3);
		chk("no control", 32'h0, {31'h0, noline});
		ctl_ok <= 1'b1;
		line_ok <= 3'b111;
		tick(1);
	endtask : t_line

	task t_trip;
		int n;
		apb(MOT_CLASS_CFG_ADDR, 1'b1, 32'h0000_051E);
		ext_byp <= 1'b1;
		run_cmd <= 1'b1;
		speed_cmd <= 1'b1;
		load_pct <= 10'd600;
		tick(300);
		apb(MOT_STATUS_ADDR, 1'b0, 32'h0);
		chk("outside bypass", 32'h0000_0064, {25'h0, rd[6:0]});
		// Run class 5 must govern once at speed; class 30 would time out here
		ext_byp <= 1'b0;
		wait_en(1'b0, 6000, n);
		chk("trip time", 32'h1, {31'h0, n >= 4995 && n <= 5010});
		tick(3);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(MOT_INT_MASK_ADDR, 1'b1, 32'h1);
		tick(2);
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(MOT_INT_STAT_ADDR, 1'b1, 32'h1);
		tick(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		// Restart need is still zero here, so reset is permitted and the lamp flashes
		n = 0;
		repeat (1000) begin
			tick(1);
			n += lamp;
		end
		chk("lamp flashing", 32'h1, {31'h0, n >= 490 && n <= 510});
		run_cmd <= 1'b0;
		speed_cmd <= 1'b0;
	endtask : t_trip

	task t_inhibit;
		int r0, sum, n;
		sum = 0;
		apb(MOT_CLASS_CFG_ADDR, 1'b1, 32'h0000_0505);
		repeat (3) begin
			apb(MOT_STATUS_ADDR, 1'b0, 32'h0);
			r0 = rd[6:0];
			run_cmd <= 1'b1;
			load_pct <= 10'd600;
			tick(150);
			// Rated current holds the heat still, so the reading stays exact
			load_pct <= 10'd100;
			tick(12);
			apb(MOT_STATUS_ADDR, 1'b0, 32'h0);
			sum += r0 - rd[6:0];
			speed_cmd <= 1'b1;
			tick(5);
			run_cmd <= 1'b0;
			speed_cmd <= 1'b0;
			tick(3);
		end
		// Cooling before a start may add one percent to a record
		apb(MOT_RESTART_CAP_ADDR, 1'b0, 32'h0);
		chk("restart mean", 32'(sum / 3), (rd == sum / 3 + 1) ? 32'(sum / 3) : rd);
		chk("view port", 32'h1, {31'h0, view >= sum / 3 && view <= sum / 3 + 1});
		run_cmd <= 1'b1;
		load_pct <= 10'd600;
		wait_en(1'b0, 6000, n);
		press();
		chk("inhibit shown", 32'h1, {31'h0, inh});
		chk("reset refused", 32'h0, {31'h0, motor_en});
		n = 0;
		repeat (200) begin
			tick(1);
			n += (lamp !== 1'b1);
		end
		chk("lamp steady", 32'h0, 32'(n));
		apb(MOT_CTRL_ADDR, 1'b1, 32'h1);
		load_pct <= 10'd100;
		tick(10);
		press();
		chk("override reset", 32'h1, {31'h0, motor_en});
		load_pct <= 10'd600;
		wait_en(1'b0, 200, n);
		run_cmd <= 1'b0;
		apb(MOT_CTRL_ADDR, 1'b1, 32'h0);
		press();
		chk("inhibit again", 32'h1, {31'h0, inh});
		n = 0;
		while (lamp === 1'b1 && n < 30000) begin
			tick(1);
			n++;
		end
		give_up(n, 30000);
		press();
		chk("cooled reset", 32'h1, {31'h0, motor_en});
	endtask : t_inhibit

	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		run_cmd = 1'b0;
		speed_cmd = 1'b0;
		ext_byp = 1'b0;
		key_cmd = 1'b0;
		load_pct = 10'h000;
		ctl_ok = 1'b1;
		line_ok = 3'b111;
		tick(2);
		sys_rst <= 1'b0;
		tick(1);
		t_regs();
		t_line();
		t_trip();
		sys_rst <= 1'b1;
		tick(2);
		sys_rst <= 1'b0;
		tick(1);
		t_inhibit();
		print_verdict();
	end
endmodule : tb_top

bind mot_overload mot_overload_assertions chk_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .at_speed(at_speed),
	.control_power_ok(control_power_ok), .line_power_ok(line_power_ok), .reset_key(reset_key),
	.motor_enable(motor_enable), .overload_lamp(overload_lamp),
	.reset_inhibit_indication(reset_inhibit_indication),
	.no_line_power_indication(no_line_power_indication),
	.restart_capacity_view(restart_capacity_view));
